// ==== src/mias_pkg.sv ====
// constants for the indirect extended-register access and strap block
// assumes apb byte address = 4 * register index, phy address field above index
package mias_pkg;
   localparam int         DATA_W          = 16;
   localparam int         CFG_W           = 9;
   localparam int         N_SPACES        = 4;
   // register indices, byte address is four times the index
   localparam logic [4:0] IDX_EXT_CTRL    = 5'h0d;
   localparam logic [4:0] IDX_EXT_DATA    = 5'h0e;
   localparam logic [4:0] IDX_CFG         = 5'h18;
   localparam logic [4:0] IDX_STRAP       = 5'h19;
   localparam logic [4:0] IDX_RESET       = 5'h1a;
   // paddr layout
   localparam int         IDX_LSB         = 2;
   localparam int         IDX_MSB         = 6;
   localparam int         PHY_LSB         = 7;
   localparam int         PHY_MSB         = 11;
   // access-control fields
   localparam int         FUNC_MSB        = 15;
   localparam int         FUNC_LSB        = 14;
   localparam int         SPACE_MSB       = 4;
   localparam int         SPACE_LSB       = 0;
   localparam logic [1:0] FUNC_ADDR       = 2'h0;
   localparam logic [1:0] FUNC_DATA       = 2'h1;
   localparam logic [1:0] FUNC_INC_RW     = 2'h2;
   localparam logic [1:0] FUNC_INC_W      = 2'h3;
   localparam logic [4:0] SPACE_VENDOR_MAIN = 5'h1f;
   localparam logic [4:0] SPACE_PMA       = 5'h01;
   localparam logic [4:0] SPACE_VENDOR_3  = 5'h03;
   localparam logic [4:0] SPACE_VENDOR_7  = 5'h07;
   // configuration word layout
   localparam int         CFG_IF_LSB      = 0;
   localparam int         CFG_IF_MSB      = 2;
   localparam int         CFG_ROLE_BIT    = 3;
   localparam int         CFG_MANAGED_BIT = 4;
   localparam int         CFG_ADDR_LSB    = 5;
   localparam int         CFG_ADDR_MSB    = 8;
   localparam int         RESET_SOFT_BIT  = 0;
   // reset values
   localparam logic [15:0]      EXT_CTRL_RST = 16'h0000;
   localparam logic [15:0]      EXT_PTR_RST  = 16'h0000;
   localparam logic [15:0]      EXT_MEM_RST  = 16'h0000;
   localparam logic [CFG_W-1:0] CFG_RST      = 9'h000;
   // strap levels and sampling delay in cycles after reset release
   localparam logic [1:0] LVL_1           = 2'h1;
   localparam logic [1:0] LVL_2           = 2'h2;
   localparam logic [1:0] LVL_3           = 2'h3;
   localparam logic [1:0] SAMPLE_DLY      = 2'h3;
endpackage

// ==== src/mias_strap.sv ====
// strap synchroniser, level resolver and latch
// assumes strap pins settle before reset release; resample is a one-cycle pulse
`timescale 1ns/100ps
module mias_strap (
   // clock and reset
   input  logic                        clk,
   input  logic                        rst,
   input  logic                        resample,
   // strap pins, asynchronous
   input  logic                        rx_data_pin_0,
   input  logic                        rx_data_pin_1,
   input  logic                        rx_data_pin_2,
   input  logic                        indicator_pin_0,
   input  logic                        indicator_pin_1,
   input  logic [1:0]                  rx_ctrl_lvl,
   input  logic [1:0]                  second_strap_lvl,
   // latched configuration
   output logic [mias_pkg::CFG_W-1:0]  strap_cfg,
   output logic                        strap_valid
);
   localparam int PIN_W = 9;

   logic [PIN_W-1:0]           meta_reg;
   logic [PIN_W-1:0]           sync_reg;
   logic [1:0]                 cnt_reg;
   logic [mias_pkg::CFG_W-1:0] latch_reg;
   logic                       valid_reg;
   logic [1:0]                 lvl_a;
   logic [1:0]                 lvl_b;
   logic [mias_pkg::CFG_W-1:0] cfg_now;

   // threshold pair to level: bit1 upper, bit0 lower
   function automatic logic [1:0] level3(input logic [1:0] th);
      if (th[1]) begin
         level3 = mias_pkg::LVL_3;
      end else if (th[0]) begin
         level3 = mias_pkg::LVL_2;
      end else begin
         level3 = mias_pkg::LVL_1;
      end
   endfunction

   function automatic logic [3:0] addr_map(input logic [1:0] a, input logic [1:0] b);
      case ({a, b})
         {mias_pkg::LVL_2, mias_pkg::LVL_1}: addr_map = 4'h4;
         {mias_pkg::LVL_3, mias_pkg::LVL_1}: addr_map = 4'h5;
         {mias_pkg::LVL_1, mias_pkg::LVL_2}: addr_map = 4'h8;
         {mias_pkg::LVL_1, mias_pkg::LVL_3}: addr_map = 4'ha;
         {mias_pkg::LVL_2, mias_pkg::LVL_2}: addr_map = 4'hc;
         {mias_pkg::LVL_3, mias_pkg::LVL_2}: addr_map = 4'hd;
         {mias_pkg::LVL_2, mias_pkg::LVL_3}: addr_map = 4'he;
         {mias_pkg::LVL_3, mias_pkg::LVL_3}: addr_map = 4'hf;
         default:                            addr_map = 4'h0;
      endcase
   endfunction

   // two-flop synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 9'h000;
         sync_reg <= 9'h000;
      end else begin
         meta_reg <= {second_strap_lvl, rx_ctrl_lvl, indicator_pin_1, indicator_pin_0,
                      rx_data_pin_2, rx_data_pin_1, rx_data_pin_0};
         sync_reg <= meta_reg;
      end
   end

   assign lvl_a   = level3(sync_reg[6:5]);
   assign lvl_b   = level3(sync_reg[8:7]);
   assign cfg_now = {addr_map(lvl_a, lvl_b), sync_reg[4:0]};

   // sampling countdown, rearmed by hardware or register reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= mias_pkg::SAMPLE_DLY;
      end else if (resample) begin
         cnt_reg <= mias_pkg::SAMPLE_DLY;
      end else if (cnt_reg != 2'h0) begin
         cnt_reg <= cnt_reg - 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_reg <= mias_pkg::CFG_RST;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= (cnt_reg == 2'h1) && !resample;
         if ((cnt_reg == 2'h1) && !resample) begin
            latch_reg <= cfg_now;
         end
      end
   end

   assign strap_cfg   = latch_reg;
   assign strap_valid = valid_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_capture;
      (cnt_reg == 2'h1) && !resample |=> valid_reg && (latch_reg == $past(cfg_now));
   endproperty
   a_capture: assert property (p_capture)
      else $error("strap capture missed");

   property p_hold;
      (cnt_reg != 2'h1) |=> $stable(latch_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("strap latch changed outside sampling");

   property p_resample;
      resample ##1 !resample [*4] |-> valid_reg;
   endproperty
   a_resample: assert property (p_resample)
      else $error("register reset did not resample straps");

   property p_addr_legal;
      !(latch_reg[8:5] inside {4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'h9, 4'hb});
   endproperty
   a_addr_legal: assert property (p_addr_legal)
      else $error("reserved station address latched");
endmodule

// ==== src/mias_top.sv ====
// apb register bank: indirect extended access and strap configuration
// assumes an apb master on clk and strap pins stable around reset
// Overview of operation
// - control bits 15:14 function, 4:0 space
// - unsupported space codes make data access ignored
// - write-only increment keeps pointer on reads
// - incrementing writes store then advance pointer
// - function 10 reads return then advance pointer
// - non-incrementing read returns selected location repeatedly
// - straps sampled at every hardware or register reset
// - each strap resolved as two or three levels
// - strap settings also writable through registers
// - three receive pins form host interface select
// - select 000 serial, 001-011 reserved
// - select 1xx reduced timing, tx clock shift at 101 and 110, rx clock shift at 110 and 111, none at 100
// - first indicator strap picks line role
// - second indicator strap picks managed operation
// - two three-level straps map to station address
`timescale 1ns/100ps
module mias_top #(
   parameter int ADDR_W = 4
) (
   // clock and reset
   input  logic        clk,
   input  logic        rst,
   // apb slave
   input  logic [11:0] paddr,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic        pready,
   output logic        pslverr,
   // strap pins
   input  logic        rx_data_pin_0,
   input  logic        rx_data_pin_1,
   input  logic        rx_data_pin_2,
   input  logic        indicator_pin_0,
   input  logic        indicator_pin_1,
   input  logic [1:0]  rx_ctrl_lvl,
   input  logic [1:0]  second_strap_lvl,
   // resolved configuration
   output logic [2:0]  host_if_select,
   output logic        host_if_serial,
   output logic        host_if_rgmii,
   output logic        host_if_reserved,
   output logic        rgmii_tx_shift,
   output logic        rgmii_rx_shift,
   output logic        line_role_select,
   output logic        managed_mode,
   output logic [3:0]  station_addr
);
   localparam int MEM_D = mias_pkg::N_SPACES * (2 ** ADDR_W);

   logic [15:0]                ctrl_reg;
   logic [15:0]                ptr_reg [mias_pkg::N_SPACES];
   logic [15:0]                mem_reg [MEM_D];
   logic [mias_pkg::CFG_W-1:0] cfg_reg;
   logic [31:0]                prdata_reg;
   logic                       pready_reg;
   logic                       pslverr_reg;
   logic                       soft_rst_reg;
   logic                       serial_reg;
   logic                       rgmii_reg;
   logic                       reserved_reg;
   logic                       tx_shift_reg;
   logic                       rx_shift_reg;
   logic [mias_pkg::CFG_W-1:0] strap_cfg;
   logic                       strap_valid;
   logic [4:0]                 idx;
   logic                       phy_match;
   logic                       hit_ctrl;
   logic                       hit_data;
   logic                       hit_cfg;
   logic                       hit_strap;
   logic                       hit_reset;
   logic                       mapped;
   logic [1:0]                 func;
   logic                       sp_ok;
   logic [1:0]                 sp_idx;
   logic [15:0]                ptr_cur;
   logic [ADDR_W+1:0]          mem_idx;
   logic [15:0]                mem_rd;
   logic                       access;
   logic                       fire;
   logic                       wr;
   logic                       rd;
   logic                       ptr_load;
   logic                       ptr_inc;
   logic                       mem_wr;
   logic [31:0]                rdata_next;
   logic                       err_next;

   // space code to {supported, index}
   function automatic logic [2:0] space_hit(input logic [4:0] s);
      case (s)
         mias_pkg::SPACE_VENDOR_MAIN: space_hit = 3'h4;
         mias_pkg::SPACE_PMA:         space_hit = 3'h5;
         mias_pkg::SPACE_VENDOR_3:    space_hit = 3'h6;
         mias_pkg::SPACE_VENDOR_7:    space_hit = 3'h7;
         default:                     space_hit = 3'h0;
      endcase
   endfunction

   mias_strap u_strap (
      .clk              (clk),
      .rst              (rst),
      .resample         (soft_rst_reg),
      .rx_data_pin_0    (rx_data_pin_0),
      .rx_data_pin_1    (rx_data_pin_1),
      .rx_data_pin_2    (rx_data_pin_2),
      .indicator_pin_0  (indicator_pin_0),
      .indicator_pin_1  (indicator_pin_1),
      .rx_ctrl_lvl      (rx_ctrl_lvl),
      .second_strap_lvl (second_strap_lvl),
      .strap_cfg        (strap_cfg),
      .strap_valid      (strap_valid)
   );

   // address decode
   assign idx       = paddr[mias_pkg::IDX_MSB:mias_pkg::IDX_LSB];
   assign phy_match = paddr[mias_pkg::PHY_MSB:mias_pkg::PHY_LSB] ==
                      {1'b0, cfg_reg[mias_pkg::CFG_ADDR_MSB:mias_pkg::CFG_ADDR_LSB]};
   assign hit_ctrl  = idx == mias_pkg::IDX_EXT_CTRL;
   assign hit_data  = idx == mias_pkg::IDX_EXT_DATA;
   assign hit_cfg   = idx == mias_pkg::IDX_CFG;
   assign hit_strap = idx == mias_pkg::IDX_STRAP;
   assign hit_reset = idx == mias_pkg::IDX_RESET;
   assign mapped    = hit_ctrl | hit_data | hit_cfg | hit_strap | hit_reset;

   // extended access decode
   assign func            = ctrl_reg[mias_pkg::FUNC_MSB:mias_pkg::FUNC_LSB];
   assign {sp_ok, sp_idx} = space_hit(ctrl_reg[mias_pkg::SPACE_MSB:mias_pkg::SPACE_LSB]);
   assign ptr_cur         = ptr_reg[sp_idx];
   assign mem_idx         = {sp_idx, ptr_cur[ADDR_W-1:0]};
   assign mem_rd          = mem_reg[mem_idx];

   // apb phases: one wait state, effect at the ready edge
   assign access   = psel & penable & !pready_reg;
   assign fire     = psel & penable & pready_reg;
   assign wr       = fire & pwrite & phy_match;
   assign rd       = fire & !pwrite & phy_match;
   assign ptr_load = wr & hit_data & sp_ok & (func == mias_pkg::FUNC_ADDR);
   assign ptr_inc  = hit_data & sp_ok & ((wr & func[1]) |
                     (rd & (func == mias_pkg::FUNC_INC_RW)));
   assign mem_wr   = wr & hit_data & sp_ok & (func != mias_pkg::FUNC_ADDR);

   always_comb begin
      rdata_next = 32'h0;
      err_next   = 1'b0;
      if (!phy_match || !mapped) begin
         err_next = 1'b1;
      end else if (hit_ctrl) begin
         rdata_next = {16'h0, ctrl_reg};
      end else if (hit_data) begin
         if (sp_ok && (func == mias_pkg::FUNC_ADDR)) begin
            rdata_next = {16'h0, ptr_cur};
         end else if (sp_ok) begin
            rdata_next = {16'h0, mem_rd};
         end
      end else if (hit_cfg) begin
         rdata_next = {{(32-mias_pkg::CFG_W){1'b0}}, cfg_reg};
      end else if (hit_strap) begin
         rdata_next = {{(32-mias_pkg::CFG_W){1'b0}}, strap_cfg};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= access;
         if (access) begin
            prdata_reg  <= pwrite ? 32'h0 : rdata_next;
            pslverr_reg <= err_next;
         end else if (fire) begin
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= mias_pkg::EXT_CTRL_RST;
      end else if (soft_rst_reg) begin
         ctrl_reg <= mias_pkg::EXT_CTRL_RST;
      end else if (wr && hit_ctrl) begin
         ctrl_reg <= pwdata[15:0];
      end
   end

   // one address pointer per space
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < mias_pkg::N_SPACES; i++) begin
            ptr_reg[i] <= mias_pkg::EXT_PTR_RST;
         end
      end else if (soft_rst_reg) begin
         for (int i = 0; i < mias_pkg::N_SPACES; i++) begin
            ptr_reg[i] <= mias_pkg::EXT_PTR_RST;
         end
      end else if (ptr_load) begin
         ptr_reg[sp_idx] <= pwdata[15:0];
      end else if (ptr_inc) begin
         ptr_reg[sp_idx] <= ptr_cur + 16'h1;
      end
   end

   // extended register storage, low pointer bits index it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < MEM_D; i++) begin
            mem_reg[i] <= mias_pkg::EXT_MEM_RST;
         end
      end else if (soft_rst_reg) begin
         for (int i = 0; i < MEM_D; i++) begin
            mem_reg[i] <= mias_pkg::EXT_MEM_RST;
         end
      end else if (mem_wr) begin
         mem_reg[mem_idx] <= pwdata[15:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= wr & hit_reset & pwdata[mias_pkg::RESET_SOFT_BIT];
      end
   end

   // strap result loaded after each reset, software may override
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_reg <= mias_pkg::CFG_RST;
      end else if (strap_valid) begin
         cfg_reg <= strap_cfg;
      end else if (wr && hit_cfg) begin
         cfg_reg <= pwdata[mias_pkg::CFG_W-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         serial_reg   <= 1'b0;
         rgmii_reg    <= 1'b0;
         reserved_reg <= 1'b0;
         tx_shift_reg <= 1'b0;
         rx_shift_reg <= 1'b0;
      end else begin
         serial_reg   <= cfg_reg[2:0] == 3'h0;
         reserved_reg <= !cfg_reg[2] && (cfg_reg[1:0] != 2'h0);
         rgmii_reg    <= cfg_reg[2];
         tx_shift_reg <= cfg_reg[2] && (cfg_reg[1:0] inside {2'h1, 2'h2});
         rx_shift_reg <= cfg_reg[2] && cfg_reg[1];
      end
   end

   assign prdata           = prdata_reg;
   assign pready           = pready_reg;
   assign pslverr          = pslverr_reg;
   assign host_if_select   = cfg_reg[mias_pkg::CFG_IF_MSB:mias_pkg::CFG_IF_LSB];
   assign host_if_serial   = serial_reg;
   assign host_if_rgmii    = rgmii_reg;
   assign host_if_reserved = reserved_reg;
   assign rgmii_tx_shift   = tx_shift_reg;
   assign rgmii_rx_shift   = rx_shift_reg;
   assign line_role_select = cfg_reg[mias_pkg::CFG_ROLE_BIT];
   assign managed_mode     = cfg_reg[mias_pkg::CFG_MANAGED_BIT];
   assign station_addr     = cfg_reg[mias_pkg::CFG_ADDR_MSB:mias_pkg::CFG_ADDR_LSB];

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_inc_write;
      wr && hit_data && sp_ok && func[1] |=> ptr_cur == $past(ptr_cur) + 16'h1;
   endproperty
   a_inc_write: assert property (p_inc_write)
      else $error("pointer did not advance after write");

   property p_inc_read;
      rd && hit_data && sp_ok && (func == mias_pkg::FUNC_INC_RW)
         |=> ptr_cur == $past(ptr_cur) + 16'h1;
   endproperty
   a_inc_read: assert property (p_inc_read)
      else $error("pointer did not advance after read");

   property p_keep_read;
      rd && hit_data && (func == mias_pkg::FUNC_INC_W) |=> $stable(ptr_cur);
   endproperty
   a_keep_read: assert property (p_keep_read)
      else $error("pointer moved on read in write-only mode");

   property p_bad_space;
      access && hit_data && phy_match && !pwrite && !sp_ok ##1 fire
         |-> prdata == 32'h0 && !pslverr ##1 $stable(ptr_cur);
   endproperty
   a_bad_space: assert property (p_bad_space)
      else $error("unsupported space was not ignored");

   property p_addr_func;
      wr && hit_data && sp_ok && (func == mias_pkg::FUNC_ADDR)
         |=> ptr_cur == $past(pwdata[15:0]);
   endproperty
   a_addr_func: assert property (p_addr_func)
      else $error("address function did not load pointer");

   property p_read_data;
      access && hit_data && phy_match && !pwrite && sp_ok && (func != mias_pkg::FUNC_ADDR)
         |=> pready && prdata[15:0] == $past(mem_rd);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("data read returned wrong location");

   property p_phy_mismatch;
      access && !phy_match |=> pready && pslverr && prdata == 32'h0;
   endproperty
   a_phy_mismatch: assert property (p_phy_mismatch)
      else $error("access with foreign station address answered");

   property p_cfg_write;
      wr && hit_cfg && !strap_valid |=> cfg_reg == $past(pwdata[mias_pkg::CFG_W-1:0]);
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("configuration write lost");

   property p_if_decode;
      ##1 host_if_rgmii == $past(cfg_reg[2]) &&
          rgmii_rx_shift == $past(cfg_reg[2] && cfg_reg[1]);
   endproperty
   a_if_decode: assert property (p_if_decode)
      else $error("interface timing decode wrong");
endmodule

// ==== test/mias_mgmt.sv ====
// management entity model: apb master with one blocking transfer task
// assumes a slave on clk that may insert any number of wait states
`timescale 1ns/100ps
module mias_mgmt (
   // clock
   input  wire logic        clk,
   // apb request
   output logic      [11:0] paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] pwdata,
   // apb answer
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      {paddr, psel, penable, pwrite, pwdata} = '0;
   end
   // request held until pready seen at a rising edge; the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

// ==== test/tb.sv ====
// bench: random straps, indirect access walks against a model, cfg and resets
// assumes mias_mgmt as the only bus master and one clock domain
`timescale 1ns/100ps
module tb;
   logic clk = 0, rst = 1, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic rx_data_pin_0, rx_data_pin_1, rx_data_pin_2, indicator_pin_0, indicator_pin_1;
   logic [1:0] rx_ctrl_lvl, second_strap_lvl;
   logic [2:0] host_if_select;
   logic host_if_serial, host_if_rgmii, host_if_reserved, rgmii_tx_shift, rgmii_rx_shift;
   logic line_role_select, managed_mode;
   logic [3:0] station_addr;
   logic [8:0] cfg_m, scfg, c;
   int error_cnt = 0, cmp_count = 0, ctrl_m, ptr_m[32], mem_m[32][16];
   int amap[3][3] = '{'{0, 8, 10}, '{4, 12, 14}, '{5, 13, 15}};
   int sp[5] = '{31, 1, 3, 7, 5};
   logic [15:0] cv[7] = '{16'h001f, 16'h801f, 16'hc01f, 16'h0001, 16'h8001, 16'hc001, 16'h4001};
   always #5 clk = ~clk;
   mias_top dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .rx_data_pin_0, .rx_data_pin_1, .rx_data_pin_2, .indicator_pin_0,
      .indicator_pin_1, .rx_ctrl_lvl, .second_strap_lvl, .host_if_select, .host_if_serial,
      .host_if_rgmii, .host_if_reserved, .rgmii_tx_shift, .rgmii_rx_shift,
      .line_role_select, .managed_mode, .station_addr);
   mias_mgmt m (.clk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic test_done;
      if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic acc(logic w, logic [4:0] idx, logic [31:0] d);
      m.xfer(w, {1'b0, cfg_m[8:5], idx, 2'b00}, d, rd, err);
   endtask
   task automatic wctl(logic [15:0] v);
      acc(1, mias_pkg::IDX_EXT_CTRL, {16'h0, v});
      ctrl_m = v;
   endtask
   task automatic ext(logic w, logic [15:0] d);
      int s, f, e;
      s = ctrl_m[4:0];
      f = ctrl_m[15:14];
      e = 0;
      acc(w, mias_pkg::IDX_EXT_DATA, {16'h0, d});
      if (s inside {31, 1, 3, 7}) begin
         if (f == 0) begin
            if (w) ptr_m[s] = d;
            e = ptr_m[s];
         end else begin
            if (w) mem_m[s][ptr_m[s] % 16] = d;
            e = mem_m[s][ptr_m[s] % 16];
            if (f == 2 || (f == 3 && w)) ptr_m[s] = (ptr_m[s] + 1) % 65536;
         end
      end
      if (!w) chk("ext_data", e, rd);
      chk("ext_err", 0, err);
   endtask
   task automatic cfg_chk;
      chk("if_sel", cfg_m[2:0], host_if_select);
      chk("if_dec", {cfg_m[2:0] == 0, cfg_m[2], cfg_m[2:0] inside {[1:3]},
         cfg_m[2:0] inside {5, 6}, cfg_m[2:0] inside {6, 7}}, {host_if_serial, host_if_rgmii,
         host_if_reserved, rgmii_tx_shift, rgmii_rx_shift});
      chk("role", cfg_m[3], line_role_select);
      chk("managed", cfg_m[4], managed_mode);
      chk("station", cfg_m[8:5], station_addr);
   endtask
   task automatic clr;
      ctrl_m = 0;
      ptr_m = '{default: 0};
      mem_m = '{default: '{default: 0}};
   endtask
   task automatic hw_reset;
      int rl, sl, p;
      @(posedge clk);
      rl = $urandom_range(3, 1);
      sl = $urandom_range(3, 1);
      p = $urandom;
      {rx_data_pin_2, rx_data_pin_1, rx_data_pin_0, indicator_pin_1, indicator_pin_0} <= p[4:0];
      rx_ctrl_lvl <= (rl == 3) ? {1'b1, p[5]} : 2'(rl - 1);
      second_strap_lvl <= (sl == 3) ? {1'b1, p[6]} : 2'(sl - 1);
      scfg = {amap[rl-1][sl-1][3:0], p[1], p[0], p[4:2]};
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      cfg_m = scfg;
      clr();
   endtask
   initial begin
      {rx_data_pin_0, rx_data_pin_1, rx_data_pin_2, indicator_pin_0, indicator_pin_1} = '0;
      {rx_ctrl_lvl, second_strap_lvl} = '0;
      void'($urandom(45021));
      for (int it = 0; it < 2; it++) begin
         hw_reset();
         cfg_chk();
         acc(1, mias_pkg::IDX_STRAP, $urandom);
         acc(0, mias_pkg::IDX_STRAP, 0);
         chk("strap_reg", cfg_m, rd);
         foreach (cv[i]) begin
            wctl(cv[i]);
            repeat (4) ext(1'($urandom), 16'($urandom));
         end
         repeat (60) begin
            if ($urandom_range(3, 0) == 0) wctl({2'($urandom), 9'h0, 5'(sp[$urandom_range(4, 0)])});
            else ext(1'($urandom), 16'($urandom));
         end
         acc(0, mias_pkg::IDX_EXT_CTRL, 0);
         chk("ctrl_reg", ctrl_m, rd);
         acc(0, 5'h05, 0);
         chk("unmapped_err", 1, err);
         chk("unmapped_rd", 0, rd);
         m.xfer(0, {1'b1, cfg_m[8:5], mias_pkg::IDX_CFG, 2'b00}, 0, rd, err);
         chk("wrong_station_err", 1, err);
         chk("wrong_station_rd", 0, rd);
         c = 9'($urandom);
         acc(1, mias_pkg::IDX_CFG, {23'h0, c});
         cfg_m = c;
         repeat (2) @(posedge clk);
         cfg_chk();
         acc(1, mias_pkg::IDX_RESET, 32'h1);
         cfg_m = scfg;
         repeat (8) @(posedge clk);
         clr();
         cfg_chk();
         wctl(16'h001f);
         ext(0, 0);
      end
      test_done();
   end
   initial begin
      #200000;
      error_cnt++;
      test_done();
   end
endmodule
